// ==== hdl/sample_timer.sv ====
// Integration and output sample timer
`timescale 1ns/1ps
module sample_timer #(
  parameter int STEP_CYCLES = sensor_cfg_pkg::STEP_CYC,
  parameter int CLK_HZ      = sensor_cfg_pkg::CLK_HZ
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  sample_timer_if.tmr     t
);
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] step;
    logic [6:0]  per;
    logic [7:0]  skp;
    logic        integ;
    logic        smp;
  } tm_t;

  tm_t q;
  tm_t d;

  always_comb
  begin
    logic [31:0] sum;
    sum = q.acc + 32'(t.n);
    d = q;
    d.integ = 1'b0;
    d.smp = 1'b0;
    if (!t.run)
    begin
      d = '0;
    end
    else if (t.rate_sel)
    begin
      // Fractional accumulator: n events per CLK_HZ cycles, no skipping
      if (sum >= 32'(CLK_HZ))
      begin
        d.acc = sum - 32'(CLK_HZ);
        d.integ = 1'b1;
        d.smp = 1'b1;
      end
      else
        d.acc = sum;
    end
    else if (q.step >= 32'(STEP_CYCLES - 1))
    begin
      d.step = '0;
      if (q.per + 7'h01 >= t.n)
      begin
        d.per = '0;
        d.integ = 1'b1;
        if (q.skp >= t.skip)
        begin
          d.skp = '0;
          d.smp = 1'b1;
        end
        else
          d.skp = q.skp + 8'h01;
      end
      else
        d.per = q.per + 7'h01;
    end
    else
      d.step = q.step + 32'h0000_0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign t.integ_tick = q.integ;
  assign t.sample     = q.smp;

  // ==========================================================
  // Checks
  a_rate_no_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(t.rate_sel) && q.integ |-> q.smp) else $error("rate form skipped");
  a_skip_zero_all: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(t.skip) == 8'h00 && q.integ |-> q.smp) else $error("zero skip lost");
endmodule : sample_timer

// ==== hdl/sensor_config_command_handler.sv ====
// Configuration command handler with AXI4-Lite register access
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sensor_config_command_handler #(
  parameter int          STEP_CYCLES = sensor_cfg_pkg::STEP_CYC,
  parameter int          CLK_HZ      = sensor_cfg_pkg::CLK_HZ,
  // Arbitrary serial number, BCD digits
  parameter logic [31:0] OWN_SERIAL  = 32'h1357_2468,
  parameter logic [23:0] MAX_PSI     = 24'h00_0014
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        nvm_parity_err,
  output logic             sample_out,
  output logic             fwd_out,
  output logic             restart_out
);
  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        p1;
    logic        p2;
    logic        bus_mode;
    logic        wdog;
    logic        unlock;
    logic        err;
    logic        run;
    logic [31:0] ser_arg;
    logic        ser_match;
    logic        rate_sel;
    logic [6:0]  n;
    logic [7:0]  skip;
    logic [7:0]  dev;
    logic [7:0]  grp;
    logic [6:0]  low;
    logic [6:0]  high;
    logic        spare;
    logic        sv_rate;
    logic [6:0]  sv_n;
    logic [7:0]  sv_skip;
    logic [7:0]  sv_dev;
    logic [7:0]  sv_grp;
    logic [6:0]  sv_low;
    logic [6:0]  sv_high;
    logic        sv_spare;
    logic        fwd_seen;
    logic        fwd_pulse;
    logic [3:0]  fwd_op;
    logic [7:0]  fwd_dst;
    logic [7:0]  fwd_arg;
    logic        rst_pend;
    logic        restart;
  } st_t;

  localparam st_t ST_RST = '{
    n: sensor_cfg_pkg::PER_DFLT, sv_n: sensor_cfg_pkg::PER_DFLT,
    grp: sensor_cfg_pkg::GRP_LO, sv_grp: sensor_cfg_pkg::GRP_LO,
    high: sensor_cfg_pkg::HIGH_MAX, sv_high: sensor_cfg_pkg::HIGH_MAX,
    default: '0};

  st_t q;
  st_t d;

  // ==========================================================
  // Helpers
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      sensor_cfg_pkg::A_CMD, sensor_cfg_pkg::A_CTRL, sensor_cfg_pkg::A_SER,
      sensor_cfg_pkg::A_STAT, sensor_cfg_pkg::A_INT, sensor_cfg_pkg::A_ADDR,
      sensor_cfg_pkg::A_FWD, sensor_cfg_pkg::A_LVL, sensor_cfg_pkg::A_MAXFS,
      sensor_cfg_pkg::A_HDR0, sensor_cfg_pkg::A_HDR1: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : reg_hit

  function automatic logic bcd_ok(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
      if (v[4*i +: 4] > 4'h9)
        ok = 1'b0;
    return ok;
  endfunction : bcd_ok

  function automatic logic needs_lock(input sensor_cfg_pkg::opcode_t o);
    return o inside {sensor_cfg_pkg::OP_RATE, sensor_cfg_pkg::OP_PERIOD,
                     sensor_cfg_pkg::OP_SKIP, sensor_cfg_pkg::OP_DEVNUM,
                     sensor_cfg_pkg::OP_LOW, sensor_cfg_pkg::OP_HIGH,
                     sensor_cfg_pkg::OP_STORE, sensor_cfg_pkg::OP_SPARE_HDR};
  endfunction : needs_lock

  // ==========================================================
  // Command decode
  sensor_cfg_pkg::opcode_t op;
  logic [7:0] arg;
  logic [7:0] dst;
  logic       commit;
  logic       bcast;
  logic       grp_hit;
  logic       own;
  logic       num_path;
  logic       addressed;
  logic       cmd_wr;
  logic       take;
  logic       lock_bad;
  logic [6:0] low_v;
  logic [6:0] high_v;

  assign op       = sensor_cfg_pkg::opcode_t'(q.w_data[3:0]);
  assign arg      = q.w_data[15:8];
  assign dst      = q.w_data[23:16];
  assign commit   = q.aw_ok && q.w_ok && !q.bvalid;
  assign bcast    = dst >= sensor_cfg_pkg::GRP_LO && dst <= sensor_cfg_pkg::ADDR_ALL;
  assign grp_hit  = dst == sensor_cfg_pkg::ADDR_ALL || dst == q.grp;
  assign own      = dst == q.dev;
  // Unlock must pass too, or a null unit could never be numbered by serial
  assign num_path = op == sensor_cfg_pkg::OP_SERIAL || op == sensor_cfg_pkg::OP_DEVNUM
                    || op == sensor_cfg_pkg::OP_UNLOCK;
  // Null-numbered bus units stay deaf to broadcasts except numbering traffic
  assign addressed = own || (bcast && grp_hit && (!q.bus_mode
                     || q.dev != sensor_cfg_pkg::ADDR_NULL || num_path));
  // Only messages framed with the active header set are recognised
  assign cmd_wr   = commit && q.aw_addr == sensor_cfg_pkg::A_CMD
                    && q.w_data[31:24] == sensor_cfg_pkg::hdr_char(3'h0, q.spare);
  assign take     = cmd_wr && addressed;
  assign lock_bad = needs_lock(op) && !q.unlock;
  assign low_v    = arg > 8'(sensor_cfg_pkg::LOW_MAX) ? sensor_cfg_pkg::LOW_MAX
                    : arg[6:0];
  assign high_v   = (arg == 8'h00 || arg > 8'(sensor_cfg_pkg::HIGH_MAX))
                    ? sensor_cfg_pkg::HIGH_MAX : arg[6:0];

  // ==========================================================
  // Next state
  always_comb
  begin
    logic set_err;
    logic clr_err;
    set_err = 1'b0;
    clr_err = 1'b0;
    d = q;
    d.p1 = nvm_parity_err;
    d.p2 = q.p1;
    d.restart = 1'b0;
    d.fwd_pulse = 1'b0;
    if (awvalid && awready)
    begin
      d.aw_ok = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      d.w_ok = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready)
      d.bvalid = 1'b0;
    if (commit)
    begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = reg_hit(q.aw_addr) ? sensor_cfg_pkg::RESP_OK : sensor_cfg_pkg::RESP_ERR;
      if (q.aw_addr == sensor_cfg_pkg::A_CTRL && q.w_strb[0])
      begin
        d.bus_mode = q.w_data[sensor_cfg_pkg::CTRL_BUS];
        d.wdog = q.w_data[sensor_cfg_pkg::CTRL_WDOG];
      end
      if (q.aw_addr == sensor_cfg_pkg::A_SER)
        for (int b = 0; b < 4; b++)
          if (q.w_strb[b])
            d.ser_arg[8*b +: 8] = q.w_data[8*b +: 8];
    end
    // Read side; reading the forward word clears its flag
    if (q.rvalid && rready)
      d.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = reg_hit(araddr) ? sensor_cfg_pkg::RESP_OK : sensor_cfg_pkg::RESP_ERR;
      unique case (araddr)
        sensor_cfg_pkg::A_CTRL: d.rdata = {30'h0000_0000, q.wdog, q.bus_mode};
        sensor_cfg_pkg::A_SER:  d.rdata = q.ser_arg;
        sensor_cfg_pkg::A_STAT: d.rdata = {28'h000_0000, q.ser_match, q.unlock, q.run, q.err};
        sensor_cfg_pkg::A_INT:  d.rdata = {15'h0000, q.rate_sel, q.skip, 1'b0, q.n};
        sensor_cfg_pkg::A_ADDR: d.rdata = {15'h0000, q.spare, q.grp, q.dev};
        sensor_cfg_pkg::A_FWD:  d.rdata = {q.fwd_seen, 11'h000, q.fwd_op, q.fwd_dst, q.fwd_arg};
        sensor_cfg_pkg::A_LVL:  d.rdata = {9'h000, q.high, 9'h000, q.low};
        sensor_cfg_pkg::A_MAXFS:
          d.rdata = {q.p2 ? sensor_cfg_pkg::CH_BANG : sensor_cfg_pkg::CH_EQ, MAX_PSI};
        sensor_cfg_pkg::A_HDR0:
          d.rdata = {sensor_cfg_pkg::hdr_char(3'h3, q.spare), sensor_cfg_pkg::hdr_char(3'h2, q.spare),
                     sensor_cfg_pkg::hdr_char(3'h1, q.spare), sensor_cfg_pkg::hdr_char(3'h0, q.spare)};
        sensor_cfg_pkg::A_HDR1:
          d.rdata = {sensor_cfg_pkg::hdr_char(3'h7, q.spare), sensor_cfg_pkg::hdr_char(3'h6, q.spare),
                     sensor_cfg_pkg::hdr_char(3'h5, q.spare), sensor_cfg_pkg::hdr_char(3'h4, q.spare)};
        default: d.rdata = 32'h0000_0000;
      endcase
      if (araddr == sensor_cfg_pkg::A_FWD)
        d.fwd_seen = 1'b0;
    end
    // Broadcasts, and on the ring anything not ours, go to the next unit
    if (cmd_wr && (bcast || (!q.bus_mode && !own)))
    begin
      d.fwd_seen = 1'b1;
      d.fwd_pulse = 1'b1;
      d.fwd_op = q.w_data[3:0];
      d.fwd_dst = dst;
      d.fwd_arg = arg;
    end
    if (take)
    begin
      d.unlock = op == sensor_cfg_pkg::OP_UNLOCK;
      if (lock_bad)
        set_err = 1'b1;
      else
        unique case (op)
          sensor_cfg_pkg::OP_NOP, sensor_cfg_pkg::OP_UNLOCK: ;
          sensor_cfg_pkg::OP_RATE, sensor_cfg_pkg::OP_PERIOD:
            if (arg == 8'h00)
            begin
              d.rate_sel = q.sv_rate;
              d.n = q.sv_n;
            end
            else if (arg > 8'(sensor_cfg_pkg::N_MAX))
              set_err = 1'b1;
            else
            begin
              d.rate_sel = op == sensor_cfg_pkg::OP_RATE;
              d.n = arg[6:0];
            end
          sensor_cfg_pkg::OP_SKIP:
            if (q.wdog && arg != 8'h00)
              set_err = 1'b1;
            else
              d.skip = arg;
          sensor_cfg_pkg::OP_DEVNUM:
            if (!q.bus_mode)
            begin
              if (arg == sensor_cfg_pkg::ADDR_NULL)
                d.dev = arg;
              else if (arg <= sensor_cfg_pkg::RING_MAX)
              begin
                d.dev = arg;
                d.fwd_arg = arg + 8'h01;
              end
              else if (arg == sensor_cfg_pkg::ADDR_LAST)
              begin
                d.dev = arg;
                d.fwd_arg = sensor_cfg_pkg::ADDR_ALL;
              end
              else if (arg >= sensor_cfg_pkg::GRP_LO && arg <= sensor_cfg_pkg::GRP_HI)
                d.grp = arg;
              else if (arg == sensor_cfg_pkg::ADDR_ALL)
                d.fwd_arg = sensor_cfg_pkg::ERR_MARK;
              else if (arg != sensor_cfg_pkg::ERR_MARK)
                set_err = 1'b1;
            end
            else
            begin
              d.ser_match = 1'b0;
              if (bcast && !q.ser_match)
                ;
              else if (arg <= sensor_cfg_pkg::ADDR_LAST)
                d.dev = arg;
              else if (arg >= sensor_cfg_pkg::GRP_LO && arg <= sensor_cfg_pkg::GRP_HI)
                d.grp = arg;
              else
                set_err = 1'b1;
            end
          sensor_cfg_pkg::OP_SERIAL:
            d.ser_match = q.bus_mode && q.ser_arg == OWN_SERIAL && bcd_ok(q.ser_arg);
          sensor_cfg_pkg::OP_INIT:
            d.run = 1'b0;
          sensor_cfg_pkg::OP_INIT_RST:
          begin
            d.run = 1'b0;
            d.rst_pend = 1'b1;
          end
          sensor_cfg_pkg::OP_LOW:
            if (low_v >= q.high)
              set_err = 1'b1;
            else
              d.low = low_v;
          sensor_cfg_pkg::OP_HIGH:
            if (high_v <= q.low)
              set_err = 1'b1;
            else
              d.high = high_v;
          sensor_cfg_pkg::OP_STORE:
          begin
            d.sv_rate = q.rate_sel;
            d.sv_n = q.n;
            d.sv_skip = q.skip;
            d.sv_dev = q.dev;
            d.sv_grp = q.grp;
            d.sv_low = q.low;
            d.sv_high = q.high;
            d.sv_spare = q.spare;
          end
          sensor_cfg_pkg::OP_SPARE_HDR:
            if (q.bus_mode)
              d.spare = !q.spare;
            else
              set_err = 1'b1;
          sensor_cfg_pkg::OP_ERR_QUERY:
            clr_err = 1'b1;
          sensor_cfg_pkg::OP_START:
            d.run = 1'b1;
          default:
            set_err = 1'b1;
        endcase
    end
    // Restart one cycle after the forward went out
    if (q.rst_pend)
    begin
      d.rst_pend = 1'b0;
      d.restart = 1'b1;
      d.rate_sel = q.sv_rate;
      d.n = q.sv_n;
      d.skip = q.sv_skip;
      d.dev = q.sv_dev;
      d.grp = q.sv_grp;
      d.low = q.sv_low;
      d.high = q.sv_high;
      d.spare = q.sv_spare;
      d.unlock = 1'b0;
      d.ser_match = 1'b0;
    end
    // A new error beats a clear in the same cycle
    d.err = (q.err && !clr_err) || set_err;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= ST_RST;
    else
      q <= d;
  end

  // ==========================================================
  // Timer and outputs
  sample_timer_if tif ();

  assign tif.run      = q.run;
  assign tif.rate_sel = q.rate_sel;
  assign tif.n        = q.n;
  assign tif.skip     = q.skip;

  sample_timer #(
    .STEP_CYCLES (STEP_CYCLES),
    .CLK_HZ      (CLK_HZ)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .t       (tif.tmr)
  );

  assign awready     = !q.aw_ok && !q.bvalid;
  assign wready      = !q.w_ok && !q.bvalid;
  assign bvalid      = q.bvalid;
  assign bresp       = q.bresp;
  assign arready     = !q.rvalid;
  assign rvalid      = q.rvalid;
  assign rdata       = q.rdata;
  assign rresp       = q.rresp;
  assign sample_out  = tif.sample;
  assign fwd_out     = q.fwd_pulse;
  assign restart_out = q.restart;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_zero_restores: assert property (take && !lock_bad && arg == 8'h00
    && (op == sensor_cfg_pkg::OP_RATE || op == sensor_cfg_pkg::OP_PERIOD)
    |=> q.n == $past(q.sv_n) && q.rate_sel == $past(q.sv_rate)) else $error("no restore");
  a_range_error: assert property (take && !lock_bad && op == sensor_cfg_pkg::OP_RATE
    && arg > 8'h78 |=> q.err && $stable(q.n)) else $error("bad rate taken");
  a_wdog_skip: assert property (take && !lock_bad && op == sensor_cfg_pkg::OP_SKIP
    && q.wdog && arg != 8'h00 |=> q.err && $stable(q.skip)) else $error("skip taken");
  a_ring_step: assert property (take && !lock_bad && !q.bus_mode
    && op == sensor_cfg_pkg::OP_DEVNUM && arg >= 8'h01 && arg <= 8'h58
    |=> q.dev == $past(arg) && q.fwd_arg == $past(arg) + 8'h01) else $error("ring step");
  a_ring_last: assert property (take && !lock_bad && !q.bus_mode
    && op == sensor_cfg_pkg::OP_DEVNUM && arg == 8'h59
    |=> q.dev == 8'h59 && q.fwd_arg == 8'h63) else $error("ring last");
  a_null_deaf: assert property (q.bus_mode && q.dev == 8'h00 && bcast
    && !num_path |-> !addressed) else $error("null unit answered");
  a_low_order: assert property (q.low < q.high) else $error("low not below high");
  a_reset_order: assert property (take && op == sensor_cfg_pkg::OP_INIT_RST && !lock_bad
    && bcast |-> ##1 fwd_out && !restart_out ##1 restart_out) else $error("reset order");
  a_lock_needed: assert property (take && lock_bad |=> q.err
    && $stable(q.n) && $stable(q.low)) else $error("unlocked change");
endmodule : sensor_config_command_handler

// ==== include/sample_timer_if.sv ====
// Link between command handler and sample timer
`timescale 1ns/1ps
interface sample_timer_if;
  logic       run;
  logic       rate_sel;
  logic [6:0] n;
  logic [7:0] skip;
  logic       integ_tick;
  logic       sample;
  modport ctl (output run, output rate_sel, output n, output skip,
               input integ_tick, input sample);
  modport tmr (input run, input rate_sel, input n, input skip,
               output integ_tick, output sample);
endinterface : sample_timer_if

// ==== include/sensor_cfg_pkg.sv ====
// Constants, opcodes and header table of the command handler
package sensor_cfg_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_MS       = 100;
  localparam int STEP_CYC      = STEP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_CTRL  = 8'h04;
  localparam logic [7:0] A_SER   = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam logic [7:0] A_INT   = 8'h10;
  localparam logic [7:0] A_ADDR  = 8'h14;
  localparam logic [7:0] A_FWD   = 8'h18;
  localparam logic [7:0] A_LVL   = 8'h1C;
  localparam logic [7:0] A_MAXFS = 8'h20;
  localparam logic [7:0] A_HDR0  = 8'h24;
  localparam logic [7:0] A_HDR1  = 8'h28;
  // ==========================================================
  // Fields, limits and reset values
  localparam int         CTRL_BUS  = 0;
  localparam int         CTRL_WDOG = 1;
  localparam logic [6:0] N_MAX     = 7'h78;
  localparam logic [6:0] PER_DFLT  = 7'h02;
  localparam logic [6:0] LOW_MAX   = 7'h63;
  localparam logic [6:0] HIGH_MAX  = 7'h64;
  localparam logic [7:0] ADDR_NULL = 8'h00;
  localparam logic [7:0] RING_MAX  = 8'h58;
  localparam logic [7:0] ADDR_LAST = 8'h59;
  localparam logic [7:0] GRP_LO    = 8'h5A;
  localparam logic [7:0] GRP_HI    = 8'h62;
  localparam logic [7:0] ADDR_ALL  = 8'h63;
  localparam logic [7:0] ERR_MARK  = 8'hEE;
  localparam logic [7:0] CH_EQ     = 8'h3D;
  localparam logic [7:0] CH_BANG   = 8'h21;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP, OP_UNLOCK, OP_RATE, OP_PERIOD, OP_SKIP, OP_DEVNUM, OP_SERIAL,
    OP_INIT, OP_INIT_RST, OP_LOW, OP_HIGH, OP_STORE, OP_SPARE_HDR,
    OP_ERR_QUERY, OP_START
  } opcode_t;

  // Header character in slot i of the standard or spare set
  function automatic logic [7:0] hdr_char(input logic [2:0] i, input logic spare);
    logic [7:0] s;
    logic [7:0] p;
    s = 8'h00;
    p = 8'h00;
    case (i)
      3'h0: begin s = 8'h2A; p = 8'h1C; end
      3'h1: begin s = 8'h24; p = 8'h1D; end
      3'h2: begin s = 8'h7E; p = 8'h1E; end
      3'h3: begin s = 8'h23; p = 8'h1F; end
      3'h4: begin s = 8'h7B; p = 8'h11; end
      3'h5: begin s = 8'h7D; p = 8'h12; end
      3'h6: begin s = 8'h21; p = 8'h13; end
      default: begin s = 8'h40; p = 8'h14; end
    endcase
    return spare ? p : s;
  endfunction : hdr_char
endpackage : sensor_cfg_pkg

// ==== tb/host_model.sv ====
// Host processor model issuing register bus transfers
`timescale 1ns/1ps
module host_model (
  input  wire logic aclk
);
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hF;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;

  // ==========================================================
  // Transfers
  // Leading idle edge keeps ready strobes from being set twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
  endtask : rd
endmodule : host_model

// ==== tb/sensor_config_command_handler_tb.sv ====
// Self-checking bench of the configuration command handler
`timescale 1ns/1ps
module sensor_config_command_handler_tb;
  logic        aclk           = 1'b0;
  logic        aresetn        = 1'b0;
  logic        nvm_parity_err = 1'b0;
  logic        sample_out, fwd_out, restart_out, seen;
  int          miscompares    = 0;
  int          checks_done    = 0;
  int          cycles         = 0;
  int          fwds           = 0;
  int          g, f0;
  logic [31:0] v;
  logic [1:0]  r;
  logic [7:0]  n, dv, gp, s;
  logic [7:0]  args [7];

  host_model host (.aclk(aclk));
  sensor_config_command_handler #(.STEP_CYCLES(10), .CLK_HZ(200)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(host.awaddr), .awvalid(host.awvalid),
    .awready(host.awready), .wdata(host.wdata), .wstrb(host.wstrb), .wvalid(host.wvalid),
    .wready(host.wready), .bresp(host.bresp), .bvalid(host.bvalid), .bready(host.bready),
    .araddr(host.araddr), .arvalid(host.arvalid), .arready(host.arready),
    .rdata(host.rdata), .rresp(host.rresp), .rvalid(host.rvalid), .rready(host.rready),
    .nvm_parity_err(nvm_parity_err), .sample_out(sample_out), .fwd_out(fwd_out),
    .restart_out(restart_out));

  initial forever #25 aclk = ~aclk;

  // ==========================================================
  // Helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
    host.rd(a, v);
    chk(v & m, exp);
  endtask : rc

  // Broadcast destination, standard header; u prepends the unlock
  task automatic cmd(input logic u, input logic [3:0] op, input logic [7:0] arg);
    if (u) host.wr(8'h00, 32'h2A63_0001, r);
    host.wr(8'h00, {8'h2A, 8'h63, arg, 4'h0, op}, r);
  endtask : cmd

  function automatic logic [7:0] ring_fwd(input logic [7:0] a);
    if (a >= 8'h01 && a <= 8'h58)
      return a + 8'h01;
    if (a == 8'h59)
      return 8'h63;
    return (a == 8'h63) ? 8'hEE : a;
  endfunction : ring_fwd

  // Cycles between two consecutive sample pulses
  task automatic gap(output int c);
    c = 0;
    @(posedge aclk iff sample_out);
    do
    begin
      @(posedge aclk);
      c++;
    end
    while (!sample_out);
  endtask : gap

  always @(posedge aclk)
  begin
    if (fwd_out)
      fwds++;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    void'($urandom(16));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h10, 32'h0000_0002);
    rc(8'h14, 32'h0000_5A00);
    rc(8'h1C, 32'h0064_0000);
    cmd(1'b0, 4'h3, 8'h05);
    rc(8'h0C, 32'h1, 32'h1);
    rc(8'h10, 32'h0000_0002);
    cmd(1'b0, 4'hD, 8'h00);
    cmd(1'b1, 4'h3, 8'h79);
    rc(8'h0C, 32'h1, 32'h1);
    rc(8'h10, 32'h0000_0002);
    cmd(1'b0, 4'hD, 8'h00);
    n = 8'($urandom_range(120, 1));
    cmd(1'b1, 4'h3, n);
    rc(8'h10, 32'(n));
    n = 8'($urandom_range(120, 1));
    cmd(1'b1, 4'h2, n);
    rc(8'h10, 32'h0001_0000 | 32'(n));
    cmd(1'b1, 4'h2, 8'h00);
    rc(8'h10, 32'h0000_0002);
    host.wr(8'h40, 32'h0, r);
    chk(32'(r), 32'(sensor_cfg_pkg::RESP_ERR));
    host.wr(8'h04, 32'h2, r);
    cmd(1'b1, 4'h4, 8'h03);
    rc(8'h0C, 32'h1, 32'h1);
    rc(8'h10, 32'h0000_0002);
    host.wr(8'h04, 32'h0, r);
    cmd(1'b0, 4'hD, 8'h00);
    n = 8'($urandom_range(255, 1));
    cmd(1'b1, 4'h4, n);
    rc(8'h10, {16'h0, n, 8'h02});
    cmd(1'b1, 4'h9, 8'hC8);
    rc(8'h1C, 32'h0064_0063);
    cmd(1'b1, 4'h9, 8'h0A);
    cmd(1'b1, 4'hA, 8'h14);
    cmd(1'b1, 4'h9, 8'h1E);
    rc(8'h0C, 32'h1, 32'h1);
    rc(8'h1C, 32'h0014_000A);
    rc(8'h20, 32'h3D00_0014);
    nvm_parity_err <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(8'h20, 32'h2100_0014);
    args = '{8'h00, 8'h01 + 8'($urandom_range(87)), 8'h58, 8'h59,
             8'h5A + 8'($urandom_range(8)), 8'h63, 8'hEE};
    dv = 8'h00;
    gp = 8'h5A;
    foreach (args[i])
    begin
      cmd(1'b1, 4'h5, args[i]);
      if (args[i] <= 8'h59) dv = args[i];
      if (args[i] >= 8'h5A && args[i] <= 8'h62) gp = args[i];
      rc(8'h18, {1'b1, 23'h0, ring_fwd(args[i])}, 32'h8000_00FF);
      rc(8'h14, {16'h0, gp, dv});
    end
    // Period 2 steps of 10 cycles, one of s+1 ticks kept
    s = 8'($urandom_range(3));
    cmd(1'b1, 4'h4, s);
    cmd(1'b0, 4'hE, 8'h00);
    gap(g);
    chk(32'(g), 32'd20 * (32'(s) + 32'd1));
    // Rate 40 per 200-cycle second, skip ignored
    cmd(1'b1, 4'h2, 8'h28);
    gap(g);
    chk(32'(g), 32'd200 / 32'd40);
    cmd(1'b0, 4'h7, 8'h00);
    rc(8'h0C, 32'h0, 32'h2);
    rc(8'h10, {15'h0, 1'b1, s, 8'h28});
    seen = 1'b0;
    f0 = fwds;
    cmd(1'b0, 4'h8, 8'h00);
    repeat (3) @(posedge aclk) if (restart_out) seen = 1'b1;
    chk(32'(seen), 32'h1);
    chk(32'(fwds - f0), 32'h1);
    rc(8'h14, 32'h0000_5A00);
    // Multidrop: null unit, serial numbering, spare headers
    host.wr(8'h04, 32'h1, r);
    host.wr(8'h08, 32'h1357_2468, r);
    cmd(1'b1, 4'h9, 8'h05);
    rc(8'h1C, 32'h0064_0000);
    cmd(1'b1, 4'h5, 8'h02);
    rc(8'h14, 32'h0000_5A00);
    cmd(1'b1, 4'h6, 8'h00);
    cmd(1'b1, 4'h5, 8'h02);
    rc(8'h14, 32'h0000_5A02);
    cmd(1'b1, 4'h9, 8'h05);
    rc(8'h1C, 32'h0064_0005);
    cmd(1'b1, 4'hC, 8'h00);
    rc(8'h24, 32'h1F1E_1D1C);
    cmd(1'b1, 4'h9, 8'h07);
    rc(8'h1C, 32'h0064_0005);
    host.wr(8'h00, 32'h1C63_0001, r);
    host.wr(8'h00, 32'h1C63_0A09, r);
    rc(8'h1C, 32'h0064_000A);
    close_out();
  end
endmodule : sensor_config_command_handler_tb
